// ==== rtl/esm_pkg.sv ====
package esm_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_FIRST_CONFIG_REGISTER = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_POS = 8'h08;
	localparam logic [7:0] ADDR_CMD = 8'h0c;
	localparam logic [7:0] ADDR_INTERPOLATION_FACTOR = 8'h10;

	// ----------------------------------------------------------------
	// Reset values and writable bits
	// ----------------------------------------------------------------
	localparam logic [31:0] FIRST_CONFIG_REGISTER_RESET = 32'h0000_0000;
	localparam logic [31:0] FIRST_CONFIG_REGISTER_WMASK = 32'h7f7f_0337;
	localparam logic [13:0] INTERPOLATION_FACTOR_RESET = 14'h0400;
	localparam int CMD_CLEAR_BIT = 0;

	// ----------------------------------------------------------------
	// Monitor groups (one mask and one latch bit each) and sources
	// ----------------------------------------------------------------
	localparam int NUM_GRP = 7;
	localparam int G_VLOW = 0;
	localparam int G_ADC = 1;
	localparam int G_OFF = 2;
	localparam int G_GAIN = 3;
	localparam int G_FAST = 4;
	localparam int G_ABZ = 5;
	localparam int G_NON = 6;
	localparam int NUM_SRC = 10;
	localparam int S_VLOW = 0;
	localparam int S_SADC = 1;
	localparam int S_CADC = 2;
	localparam int S_SOFF = 3;
	localparam int S_COFF = 4;
	localparam int S_SGAIN = 5;
	localparam int S_CGAIN = 6;
	localparam int S_FAST = 7;
	localparam int S_ABZ = 8;
	localparam int S_NON = 9;
	localparam int SRC_GRP [NUM_SRC] = '{0, 1, 1, 2, 2, 3, 3, 4, 5, 6};
	// Sources feeding the serial warning and error bits; square-wave invalid feeds neither.
	localparam logic [9:0] WARN_SET = 10'h078;
	localparam logic [9:0] ERR_SET = 10'h287;

	// ----------------------------------------------------------------
	// Frequency and amplitude limits
	// ----------------------------------------------------------------
	localparam logic [31:0] COUNTER_DIV = 32'h0000_0118;
	localparam logic [31:0] NONIUS_DIV = 32'h0000_00c6;
	localparam logic [31:0] ABZ_MARGIN_NUM = 32'h0000_0009;
	localparam logic [31:0] ABZ_MARGIN_DEN = 32'h0000_000a;
	localparam logic [31:0] VLOW_PCT = 32'h0000_001e;
	localparam logic [31:0] PCT_FULL = 32'h0000_0064;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic spare_hi;
		logic [6:0] latch;
		logic spare_mid;
		logic [6:0] mask;
		logic [5:0] rsv_hi;
		logic tri_on_fault;
		logic freeze_outputs_on_fault;
		logic [1:0] rsv_mid;
		logic [1:0] output_rate_divider;
		logic rsv_lo;
		logic [2:0] edge_spacing_setting;
	} esm_cfg_t;

	typedef struct packed {
		logic a;
		logic b;
		logic z;
	} esm_sq_t;

endpackage

// ==== rtl/esm_monitor.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Nonius check enabled: flag result above oscillator frequency over 198.
// - Speed check: flag when input exceeds oscillator frequency over 280.
// - Square-wave limit is 0.9 times oscillator over edge spacing times output rate.
// - Each monitoring group is gated by its own mask bit in config; sine and cosine sources share one.
// - Latch bit set holds flag after condition ends; clear follows live condition.
// - Fault pin goes low when any enabled flag is present.
// - Freeze bit holds square-wave outputs while a fault is present.
// - High-impedance bit turns off square-wave drivers while a fault is present.
// - Clear command or counter load pulse clears latched flags.
// - Vector below 30 percent of nominal raises low-vector error.
// - Overdrive has sine and cosine bits, one mask, one latch, serial error.
// - Offset limit has sine and cosine bits and reports a serial warning.
// - Gain limit has sine and cosine bits and reports a serial warning.
// - Overspeed is a serial error, gated by the speed check enable.
// - Square-wave invalid set on excess frequency or rate/spacing change; not serial.
// - Implausible absolute result is a serial error, gated by its check enable.
// - Serial streams carry one warning and one error bit.
// - Faults show in status register; serial-error faults also as error bit in position register.
// - Edge spacing is 1 to 128 oscillator periods by a three-bit field.
module esm_monitor #(
	parameter logic [15:0] NOMINAL_AMPL = 16'h4000
) (
	// AHB-Lite slave
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Conditions from the analog front end and controllers
	input wire logic [15:0] vector_mag,
	input wire logic sin_overdrive,
	input wire logic cos_overdrive,
	input wire logic sin_offset_lim,
	input wire logic cos_offset_lim,
	input wire logic sin_gain_lim,
	input wire logic cos_gain_lim,
	input wire logic abs_implausible,
	input wire logic [23:0] period_cycles,
	input wire logic period_valid,
	input wire logic [30:0] abs_position,
	input wire logic counter_load_pulse,
	// Square waves from the interpolator and to the pins
	input wire esm_pkg::esm_sq_t sq_in,
	output esm_pkg::esm_sq_t sq_out,
	output esm_pkg::esm_sq_t sq_oe,
	// Fault reporting
	output logic fault_out_n,
	output logic serial_warning,
	output logic serial_error
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	esm_pkg::esm_cfg_t cfg_reg, cfg_next;
	logic [13:0] interpolation_factor_reg, interpolation_factor_next;
	logic [9:0] flag_reg, flag_next;
	logic chg_reg, chg_next;
	logic clr_reg, clr_next;
	logic wr_pend_reg, wr_pend_next;
	logic [7:0] wr_addr_reg, wr_addr_next;
	logic [31:0] hrdata_reg, hrdata_next;
	esm_pkg::esm_sq_t sq_out_reg, sq_out_next;
	esm_pkg::esm_sq_t sq_oe_reg, sq_oe_next;
	logic fault_n_reg, fault_n_next;
	logic warn_reg, warn_next;
	logic err_reg, err_next;

	logic [9:0] live;
	logic [31:0] period32;
	logic [31:0] n_square_wave_output_rate;
	logic vec_low, over_cnt, over_non, over_abz, fault_any, addr_ok, clr_any;

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	// Zero wait states: read data is picked in the address phase so that it
	// stands from a flip-flop through the data phase. Writes land at the end
	// of the data phase, so a read right after a write sees the old value.
	always_comb begin
		addr_ok = hsel && htrans[1] && hready;
		wr_pend_next = addr_ok && hwrite;
		wr_addr_next = haddr[7:0];
		hrdata_next = hrdata_reg;
		if (addr_ok && !hwrite) begin
			unique case (haddr[7:0])
				esm_pkg::ADDR_FIRST_CONFIG_REGISTER: hrdata_next = cfg_reg;
				esm_pkg::ADDR_STAT: hrdata_next = {22'h000000, flag_reg};
				esm_pkg::ADDR_POS: hrdata_next = {|(flag_reg & esm_pkg::ERR_SET), abs_position};
				esm_pkg::ADDR_INTERPOLATION_FACTOR: hrdata_next = {18'h00000, interpolation_factor_reg};
				default: hrdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata_reg <= 32'h0000_0000;
		end else begin
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
			hrdata_reg <= hrdata_next;
		end
	end

	// ----------------------------------------------------------------
	// Configuration and command registers
	// ----------------------------------------------------------------
	// A write that alters the rate or the edge spacing leaves the square
	// waves briefly inconsistent, so it is reported as an event.
	always_comb begin
		cfg_next = cfg_reg;
		interpolation_factor_next = interpolation_factor_reg;
		chg_next = 1'b0;
		clr_next = 1'b0;
		if (wr_pend_reg) begin
			if (wr_addr_reg == esm_pkg::ADDR_FIRST_CONFIG_REGISTER) begin
				cfg_next = hwdata & esm_pkg::FIRST_CONFIG_REGISTER_WMASK;
				chg_next = (hwdata[5:0] & 6'h37) != (cfg_reg[5:0] & 6'h37);
			end
			if (wr_addr_reg == esm_pkg::ADDR_INTERPOLATION_FACTOR) begin
				interpolation_factor_next = hwdata[13:0];
				chg_next = hwdata[13:0] != interpolation_factor_reg;
			end
			if (wr_addr_reg == esm_pkg::ADDR_CMD) begin
				clr_next = hwdata[esm_pkg::CMD_CLEAR_BIT];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_reg <= esm_pkg::FIRST_CONFIG_REGISTER_RESET;
			interpolation_factor_reg <= esm_pkg::INTERPOLATION_FACTOR_RESET;
			chg_reg <= 1'b0;
			clr_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			interpolation_factor_reg <= interpolation_factor_next;
			chg_reg <= chg_next;
			clr_reg <= clr_next;
		end
	end

	// ----------------------------------------------------------------
	// Live conditions
	// ----------------------------------------------------------------
	// The edge spacing is 2 to the power of the setting (1..128 periods),
	// and the output rate is the interpolation rate shifted down by the divider.
	always_comb begin
		period32 = {8'h00, period_cycles};
		n_square_wave_output_rate = ({18'h00000, interpolation_factor_reg} >> cfg_reg.output_rate_divider) << cfg_reg.edge_spacing_setting;
		vec_low = ({16'h0000, vector_mag} * esm_pkg::PCT_FULL) < ({16'h0000, NOMINAL_AMPL} * esm_pkg::VLOW_PCT);
		over_cnt = period_valid && (period32 < esm_pkg::COUNTER_DIV);
		over_non = period_valid && (period32 < esm_pkg::NONIUS_DIV);
		over_abz = period_valid && ((period32 * esm_pkg::ABZ_MARGIN_NUM) < (n_square_wave_output_rate * esm_pkg::ABZ_MARGIN_DEN));
		live[esm_pkg::S_VLOW] = vec_low;
		live[esm_pkg::S_SADC] = sin_overdrive;
		live[esm_pkg::S_CADC] = cos_overdrive;
		live[esm_pkg::S_SOFF] = sin_offset_lim;
		live[esm_pkg::S_COFF] = cos_offset_lim;
		live[esm_pkg::S_SGAIN] = sin_gain_lim;
		live[esm_pkg::S_CGAIN] = cos_gain_lim;
		live[esm_pkg::S_FAST] = over_cnt;
		live[esm_pkg::S_ABZ] = over_abz || chg_reg;
		live[esm_pkg::S_NON] = abs_implausible || over_non;
		clr_any = clr_reg || counter_load_pulse;
	end

	// ----------------------------------------------------------------
	// Fault flags
	// ----------------------------------------------------------------
	// A live condition wins over a clear in the same cycle, so no event is lost.
	genvar gi;
	generate
		for (gi = 0; gi < esm_pkg::NUM_SRC; gi++) begin : g_flag
			assign flag_next[gi] = cfg_reg.mask[esm_pkg::SRC_GRP[gi]] &&
				(live[gi] || (cfg_reg.latch[esm_pkg::SRC_GRP[gi]] && flag_reg[gi] && !clr_any));
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_reg <= 10'h000;
		end else begin
			flag_reg <= flag_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs: fault pin, serial bits, square-wave gating
	// ----------------------------------------------------------------
	always_comb begin
		fault_any = |flag_reg;
		fault_n_next = !fault_any;
		warn_next = |(flag_reg & esm_pkg::WARN_SET);
		err_next = |(flag_reg & esm_pkg::ERR_SET);
		sq_out_next = (fault_any && cfg_reg.freeze_outputs_on_fault) ? sq_out_reg : sq_in;
		sq_oe_next = (fault_any && cfg_reg.tri_on_fault) ? 3'b000 : 3'b111;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault_n_reg <= 1'b1;
			warn_reg <= 1'b0;
			err_reg <= 1'b0;
			sq_out_reg <= 3'b000;
			sq_oe_reg <= 3'b000;
		end else begin
			fault_n_reg <= fault_n_next;
			warn_reg <= warn_next;
			err_reg <= err_next;
			sq_out_reg <= sq_out_next;
			sq_oe_reg <= sq_oe_next;
		end
	end

	assign hrdata = hrdata_reg;
	assign hreadyout = hresetn;
	assign hresp = 1'b0;
	assign sq_out = sq_out_reg;
	assign sq_oe = sq_oe_reg;
	assign fault_out_n = fault_n_reg;
	assign serial_warning = warn_reg;
	assign serial_error = err_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_MASK_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
		!cfg_reg.mask[esm_pkg::G_ADC] |=> !flag_reg[esm_pkg::S_SADC] && !flag_reg[esm_pkg::S_CADC])
		else $error("Masked overdrive source raised a flag.");

	AST_LATCH_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
		cfg_reg.mask[esm_pkg::G_VLOW] && cfg_reg.latch[esm_pkg::G_VLOW] && flag_reg[esm_pkg::S_VLOW]
		&& !clr_any && cfg_next.mask[esm_pkg::G_VLOW] |=> flag_reg[esm_pkg::S_VLOW] [*1])
		else $error("Latched low-vector flag was lost.");

	AST_FOLLOW_LIVE: assert property (@(posedge hclk) disable iff (!hresetn)
		!cfg_reg.latch[esm_pkg::G_FAST] && !live[esm_pkg::S_FAST] |=> !flag_reg[esm_pkg::S_FAST])
		else $error("Unlatched overspeed flag did not follow the condition.");

	AST_FAULT_PIN: assert property (@(posedge hclk) disable iff (!hresetn)
		live[esm_pkg::S_SOFF] && cfg_reg.mask[esm_pkg::G_OFF] |=> ##1 !fault_out_n && serial_warning)
		else $error("Offset limit did not reach the fault pin and warning bit.");

	AST_FREEZE: assert property (@(posedge hclk) disable iff (!hresetn)
		fault_any && cfg_reg.freeze_outputs_on_fault |=> sq_out == $past(sq_out))
		else $error("Square-wave outputs moved during a fault with freeze set.");

	AST_HIGHZ: assert property (@(posedge hclk) disable iff (!hresetn)
		fault_any && cfg_reg.tri_on_fault |=> sq_oe == 3'b000)
		else $error("Square-wave drivers stayed on during a fault.");

	AST_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
		clr_any && live == 10'h000 |=> flag_reg == 10'h000 ##1 fault_out_n)
		else $error("Clear did not remove the flags and release the pin.");

	AST_VLOW: assert property (@(posedge hclk) disable iff (!hresetn)
		vec_low && cfg_reg.mask[esm_pkg::G_VLOW] |=> flag_reg[esm_pkg::S_VLOW] ##1 serial_error)
		else $error("Low vector was not reported as an error.");

	AST_SPEED: assert property (@(posedge hclk) disable iff (!hresetn)
		period_valid && period_cycles < 24'h000118 && cfg_reg.mask[esm_pkg::G_FAST] |=> flag_reg[esm_pkg::S_FAST])
		else $error("Overspeed below 280 cycles per period was missed.");

	AST_RATE_CHG: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend_reg && wr_addr_reg == esm_pkg::ADDR_INTERPOLATION_FACTOR && hwdata[13:0] != interpolation_factor_reg
		&& cfg_reg.mask[esm_pkg::G_ABZ] && cfg_next.mask[esm_pkg::G_ABZ] |=> ##1 flag_reg[esm_pkg::S_ABZ])
		else $error("Rate change did not flag the square waves invalid.");

	AST_ABZ_SILENT: assert property (@(posedge hclk) disable iff (!hresetn)
		flag_reg == (10'h001 << esm_pkg::S_ABZ) |=> !serial_error && !serial_warning)
		else $error("Square-wave invalid leaked into the serial bits.");

endmodule

// ==== verif/esm_host_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host on the register bus
// ----------------------------------------------------------------
module esm_host_model (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite master
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Set when the slave never answered
	output logic timed_out
);
	// Bus idle at time zero.
	initial begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		timed_out = 1'b0;
	end

	// Bounded wait for hready high at a rising edge, so a stuck slave ends the run.
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 64);
		if (n >= 64) timed_out <= 1'b1;
	endtask

	// One single word transfer; call just after a rising edge.
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask
endmodule

// ==== verif/encoder_signal_fault_monitor_test.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; $display("ERROR %0t: line %0d got %h want %h", $time, `__LINE__, (a), (b)); end end
// ----------------------------------------------------------------
// Fault monitor bench
// ----------------------------------------------------------------
module encoder_signal_fault_monitor_test;
	logic hclk, hresetn, hwrite, hsel, hready, hresp, timed_out;
	logic [31:0] haddr, hwdata, hrdata, seed;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] vector_mag;
	logic [5:0] disc;
	logic abs_implausible, period_valid, counter_load_pulse, fault_out_n, serial_warning, serial_error;
	logic [23:0] period_cycles;
	logic [30:0] abs_pos;
	esm_pkg::esm_sq_t sq_in, sq_out, sq_oe;
	int fail_count, num_checks, g;

	esm_host_model u_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .timed_out(timed_out));
	esm_monitor u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
		.hresp(hresp), .vector_mag(vector_mag), .sin_overdrive(disc[0]), .cos_overdrive(disc[1]),
		.sin_offset_lim(disc[2]), .cos_offset_lim(disc[3]), .sin_gain_lim(disc[4]), .cos_gain_lim(disc[5]),
		.abs_implausible(abs_implausible), .period_cycles(period_cycles), .period_valid(period_valid),
		.abs_position(abs_pos), .counter_load_pulse(counter_load_pulse), .sq_in(sq_in), .sq_out(sq_out),
		.sq_oe(sq_oe), .fault_out_n(fault_out_n), .serial_warning(serial_warning), .serial_error(serial_error));

	// Clock at 200 MHz.
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] unused;
		u_host.xfer(1'b1, a, d, unused);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		u_host.xfer(1'b0, a, 32'h0000_0000, d);
	endtask

	// Drive the live condition behind one status bit.
	task automatic set_src(input int s, input logic v);
		case (s)
			0: vector_mag <= v ? 16'h0100 : 16'h4000;
			7: period_cycles <= v ? 24'h000117 : 24'h0fffff;
			8: period_cycles <= v ? 24'h000471 : 24'h0fffff;
			9: abs_implausible <= v;
			default: disc[s - 1] <= v;
		endcase
	endtask

	// Offset and gain are warnings; square-wave invalid is in neither serial bit.
	task automatic expect_flags(input logic [9:0] f);
		logic [31:0] d;
		logic e;
		e = f[0] | f[1] | f[2] | f[7] | f[9];
		`CHK(fault_out_n, ~|f)
		`CHK(serial_warning, |f[6:3])
		`CHK(serial_error, e)
		rd(esm_pkg::ADDR_STAT, d);
		`CHK(d, {22'h00_0000, f})
		rd(esm_pkg::ADDR_POS, d);
		`CHK(d, {e, abs_pos})
	endtask

	task automatic clear_flags(input logic by_pin);
		if (by_pin) begin
			counter_load_pulse <= 1'b1;
			@(posedge hclk);
			counter_load_pulse <= 1'b0;
		end else begin
			wr(esm_pkg::ADDR_CMD, 32'h0000_0001);
		end
		cyc(3);
	endtask

	// A slave that never answers ends the run.
	always @(posedge hclk) begin
		if (timed_out) begin
			fail_count++;
			print_verdict();
		end
	end

	initial begin
		#300000;
		fail_count++;
		print_verdict();
	end

	initial begin
		logic [31:0] d, r;
		seed = 32'h0001_5e34;
		hresetn = 1'b0;
		vector_mag = 16'h4000;
		disc = 6'h00;
		abs_implausible = 1'b0;
		period_cycles = 24'h0fffff;
		period_valid = 1'b1;
		counter_load_pulse = 1'b0;
		sq_in = 3'b000;
		abs_pos = xs();
		fail_count = 0;
		num_checks = 0;
		cyc(16);
		`CHK(fault_out_n, 1'b1)
		`CHK(sq_oe, 3'b000)
		hresetn <= 1'b1;
		cyc(2);
		rd(esm_pkg::ADDR_FIRST_CONFIG_REGISTER, d);
		`CHK(d, esm_pkg::FIRST_CONFIG_REGISTER_RESET)
		rd(esm_pkg::ADDR_INTERPOLATION_FACTOR, d);
		`CHK(d, {18'h0_0000, esm_pkg::INTERPOLATION_FACTOR_RESET})
		rd(8'h20, d);
		`CHK(d, 32'h0000_0000)
		`CHK(hresp, 1'b0)
		r = xs();
		wr(esm_pkg::ADDR_FIRST_CONFIG_REGISTER, r);
		rd(esm_pkg::ADDR_FIRST_CONFIG_REGISTER, d);
		`CHK(d, r & esm_pkg::FIRST_CONFIG_REGISTER_WMASK)
		wr(esm_pkg::ADDR_FIRST_CONFIG_REGISTER, 32'h0000_0000);
		cyc(3);
		expect_flags(10'h000);
		// recommended upper half for position plus counter
		wr(esm_pkg::ADDR_FIRST_CONFIG_REGISTER, 32'h77f7_0000);
		rd(esm_pkg::ADDR_FIRST_CONFIG_REGISTER, d);
		`CHK(d, 32'h77f7_0000 & esm_pkg::FIRST_CONFIG_REGISTER_WMASK)
		// square waves unused, so their rate check stays off
		wr(esm_pkg::ADDR_FIRST_CONFIG_REGISTER, 32'h0011_0000);
		cyc(3);
		expect_flags(10'h000);
		$display("test registers done");
		// mask, latch and clear of every source
		for (int s = 0; s < 10; s++) begin
			g = esm_pkg::SRC_GRP[s];
			for (int l = 0; l < 2; l++) begin
				wr(esm_pkg::ADDR_FIRST_CONFIG_REGISTER, (32'h1 << (16 + g)) | (32'(l) << (24 + g)));
				set_src(s, 1'b1);
				cyc(3);
				expect_flags(10'h001 << s);
				set_src(s, 1'b0);
				cyc(3);
				expect_flags(l ? (10'h001 << s) : 10'h000);
				clear_flags(s[0]);
				expect_flags(10'h000);
			end
			wr(esm_pkg::ADDR_FIRST_CONFIG_REGISTER, 32'h0000_0000);
			set_src(s, 1'b1);
			cyc(3);
			expect_flags(10'h000);
			set_src(s, 1'b0);
			cyc(3);
		end
		$display("test sources done");
		// speed and square-wave checks on while square waves are in use
		wr(esm_pkg::ADDR_FIRST_CONFIG_REGISTER, 32'h0131_0100);
		sq_in <= 3'b101;
		cyc(3);
		`CHK(sq_out, 3'b101)
		set_src(0, 1'b1);
		cyc(3);
		set_src(0, 1'b0);
		sq_in <= 3'b010;
		cyc(3);
		`CHK(sq_out, 3'b101)
		`CHK(sq_oe, 3'b111)
		wr(esm_pkg::ADDR_FIRST_CONFIG_REGISTER, 32'h0131_0300);
		cyc(2);
		`CHK(sq_oe, 3'b000)
		// results read while flagged are discarded here
		clear_flags(1'b1);
		`CHK(sq_out, 3'b010)
		`CHK(sq_oe, 3'b111)
		$display("test outputs done");
		// rate change marks square waves invalid
		period_valid <= 1'b0;
		wr(esm_pkg::ADDR_FIRST_CONFIG_REGISTER, 32'h2020_0000);
		cyc(3);
		expect_flags(10'h000);
		wr(esm_pkg::ADDR_INTERPOLATION_FACTOR, 32'h0000_0800);
		cyc(3);
		expect_flags(10'h100);
		rd(esm_pkg::ADDR_INTERPOLATION_FACTOR, d);
		`CHK(d, 32'h0000_0800)
		clear_flags(1'b0);
		expect_flags(10'h000);
		$display("test rate change done");
		print_verdict();
	end
endmodule
